// ### design/bab_core.sv
// bab_core: executes the literal add/and, file add/and, bit clear and carry/negative
// branches of an 8-bit core, one instruction cycle of four clocks each, two cycles for a taken branch.
// assumes a data memory that returns read data one clock after mem_addr/mem_re,
// and fetch logic on the same clock that holds instr_word while instr_valid.
`timescale 1ns/1ps
module bab_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // instruction fetch
    input wire logic [bab_pkg::WORD_W-1:0] instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    // addressing context
    input wire logic ext_set_enable,
    input wire logic [bab_pkg::BANK_W-1:0] bank_select_reg,
    input wire logic [bab_pkg::ADDR_W-1:0] index_base,
    // data memory
    output logic [bab_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_re,
    input wire logic [bab_pkg::DATA_W-1:0] mem_rdata,
    output logic mem_we,
    output logic [bab_pkg::DATA_W-1:0] mem_wdata,
    // architectural state
    output logic [bab_pkg::DATA_W-1:0] acc,
    output logic [bab_pkg::FLAG_W-1:0] status,
    output logic [bab_pkg::PC_W-1:0] pc
);
    import bab_pkg::*;

    bab_phase_type phase;
    bab_phase_type next_phase;
    logic [WORD_W-1:0] ir;
    logic flush;
    logic next_flush;
    // flush_armed marks that the idle cycle has begun, so the first write ends nothing
    logic flush_armed;

    // fetch side decode, used only for the operand address and the read strobe at the take edge
    wire take = instr_ready && instr_valid;
    wire [7:0] in_f = instr_word[7:0];
    wire in_acc_bit = instr_word[ACC_BIT];
    wire in_file_op = (instr_word[15:10] == OP_ADD_FILE_C) || (instr_word[15:10] == OP_ADD_FILE)
        || (instr_word[15:10] == OP_AND_FILE) || (instr_word[15:12] == OP_BIT_CLEAR);
    wire in_indexed = ext_set_enable && !in_acc_bit && (in_f <= INDEX_LIMIT);
    wire [BANK_W-1:0] access_bank = (in_f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
    wire [ADDR_W-1:0] eff_addr = in_indexed ? ADDR_W'(index_base + {4'h0, in_f})
        : in_acc_bit ? {bank_select_reg, in_f} : {access_bank, in_f};

    // execute side decode on the latched word
    wire is_add_lit = ir[15:8] == OP_ADD_LIT;
    wire is_and_lit = ir[15:8] == OP_AND_LIT;
    wire is_add_file_c = ir[15:10] == OP_ADD_FILE_C;
    wire is_add_file = ir[15:10] == OP_ADD_FILE;
    wire is_and_file = ir[15:10] == OP_AND_FILE;
    wire is_bit_clear = ir[15:12] == OP_BIT_CLEAR;
    wire is_br_carry = ir[15:8] == OP_BR_CARRY;
    wire is_br_neg = ir[15:8] == OP_BR_NEG;
    wire is_add = is_add_lit || is_add_file || is_add_file_c;
    wire is_and = is_and_lit || is_and_file;
    wire to_file = (is_add_file || is_add_file_c || is_and_file) && ir[DEST_BIT];

    // alu
    wire [DATA_W-1:0] opnd = (is_add_lit || is_and_lit) ? ir[7:0] : mem_rdata;
    wire cin = is_add_file_c && status[FLG_C];
    wire [DATA_W:0] sum = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin};
    wire [4:0] low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    wire add_ov = (acc[7] == opnd[7]) && (sum[7] != acc[7]);
    wire [DATA_W-1:0] and_res = acc & opnd;
    wire [DATA_W-1:0] clr_mask = ~(DATA_W'(1) << ir[BITSEL_LSB+2:BITSEL_LSB]);
    wire [DATA_W-1:0] clr_res = mem_rdata & clr_mask;
    wire [DATA_W-1:0] result = is_add ? sum[DATA_W-1:0] : is_bit_clear ? clr_res : and_res;

    // flag update: add touches all five, and touches N and Z, the rest none
    wire [FLAG_W-1:0] add_flags = {result[7], add_ov, result == 8'h00, low_sum[4], sum[8]};
    wire [FLAG_W-1:0] and_flags = {result[7], status[FLG_OV], result == 8'h00,
        status[FLG_DC], status[FLG_C]};
    wire [FLAG_W-1:0] next_status = is_add ? add_flags : is_and ? and_flags : status;

    // branches; pc already points past this word, so target is pc + 2n
    wire br_taken = (is_br_carry && status[FLG_C]) || (is_br_neg && status[FLG_N]);
    wire [PC_W-1:0] br_offset = {{(PC_W-9){ir[7]}}, ir[7:0], 1'b0};
    wire [PC_W-1:0] br_target = pc + br_offset;

    wire exec = (phase == BAB_PROCESS) && !flush;

    // quarter sequencer; a taken branch inserts one full idle cycle
    always_comb begin
        next_phase = phase;
        next_flush = flush;
        case (phase)
            BAB_DECODE: begin
                if (take || flush) begin
                    next_phase = BAB_READ;
                end
            end
            BAB_READ: next_phase = BAB_PROCESS;
            BAB_PROCESS: begin
                next_phase = BAB_WRITE;
                if (exec && br_taken) begin
                    next_flush = 1'b1;
                end
            end
            BAB_WRITE: begin
                next_phase = BAB_DECODE;
                if (flush) begin
                    next_flush = !flush_armed;
                end
            end
            default: next_phase = BAB_DECODE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flush_armed <= 1'b0;
        end else if (phase == BAB_WRITE) begin
            flush_armed <= next_flush;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= BAB_DECODE;
            flush <= 1'b0;
            instr_ready <= 1'b0;
        end else begin
            phase <= next_phase;
            flush <= next_flush;
            instr_ready <= (next_phase == BAB_DECODE) && !next_flush;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir <= '0;
            pc <= PC_RESET;
            mem_addr <= ADDR_RESET;
            mem_re <= 1'b0;
        end else begin
            mem_re <= take && in_file_op;
            if (take) begin
                ir <= instr_word;
                pc <= pc + PC_STEP;
                mem_addr <= eff_addr;
            end else if (exec && br_taken) begin
                pc <= br_target;
            end
        end
    end

    // destination write lands in the fourth quarter
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc <= ACC_RESET;
            status <= FLAGS_RESET;
            mem_we <= 1'b0;
            mem_wdata <= DATA_RESET;
        end else begin
            mem_we <= exec && (to_file || is_bit_clear);
            if (exec) begin
                status <= next_status;
                mem_wdata <= result;
                if ((is_add || is_and) && !to_file) begin
                    acc <= result;
                end
            end
        end
    end

    wire [7:0] bit_one = DATA_W'(1) << ir[BITSEL_LSB+2:BITSEL_LSB];

    property p_lit_add;
        @(posedge sys_clk) disable iff (!reset_n)
        (exec && is_add_lit) |=> acc == 8'($past(acc) + $past(ir[7:0]));
    endproperty
    a_lit_add: assert property (p_lit_add) else $error("literal add wrong sum");

    property p_carry_add;
        @(posedge sys_clk) disable iff (!reset_n)
        (exec && is_add_file_c && !ir[DEST_BIT]) |=>
            acc == 8'($past(acc) + $past(mem_rdata) + $past({7'h00, status[FLG_C]}));
    endproperty
    a_carry_add: assert property (p_carry_add) else $error("carry add wrong sum");

    property p_dest_file;
        @(posedge sys_clk) disable iff (!reset_n)
        (exec && to_file) |=> mem_we && $stable(acc) ##1 !mem_we;
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file destination not honoured");

    property p_bank_addr;
        @(posedge sys_clk) disable iff (!reset_n)
        (take && in_file_op && in_acc_bit) |=>
            mem_addr == {$past(bank_select_reg), $past(instr_word[7:0])};
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("bank address wrong");

    property p_indexed;
        @(posedge sys_clk) disable iff (!reset_n)
        (take && in_file_op && ext_set_enable && !in_acc_bit && in_f <= INDEX_LIMIT) |=>
            mem_addr == 12'($past(index_base) + {4'h0, $past(instr_word[7:0])});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_and_flags;
        @(posedge sys_clk) disable iff (!reset_n)
        (exec && is_and_file) |=> $stable(status[FLG_OV]) && $stable(status[FLG_C])
            && status[FLG_Z] == (8'($past(acc) & $past(mem_rdata)) == 8'h00);
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("and touched wrong flags");

    property p_bit_clear;
        @(posedge sys_clk) disable iff (!reset_n)
        (exec && is_bit_clear) |=> mem_we
            && (mem_wdata == ($past(mem_rdata) & ~$past(bit_one)))
            && $stable(status);
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

    property p_no_carry;
        @(posedge sys_clk) disable iff (!reset_n)
        (exec && is_br_carry && !status[FLG_C]) |=> $stable(pc) && $stable(status);
    endproperty
    a_no_carry: assert property (p_no_carry) else $error("branch taken without carry");

    property p_target;
        @(posedge sys_clk) disable iff (!reset_n)
        (exec && is_br_neg && status[FLG_N]) |=>
            pc == 21'($past(pc) + {{12{$past(ir[7])}}, $past(ir[7:0]), 1'b0});
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");

    property p_taken_len;
        @(posedge sys_clk) disable iff (!reset_n)
        (exec && br_taken) |=> (!instr_ready) [*5] ##1 instr_ready;
    endproperty
    a_taken_len: assert property (p_taken_len) else $error("taken branch not two cycles");

    property p_cycle_len;
        @(posedge sys_clk) disable iff (!reset_n)
        (take && !(instr_word[15:8] == OP_BR_CARRY || instr_word[15:8] == OP_BR_NEG)) |=>
            (!instr_ready) [*3] ##1 instr_ready;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle not four quarters");
endmodule

// ### design/bab_pkg.sv
// bab_pkg: constants shared by the byte alu / branch execute unit.
// assumes one 100 MHz clock; the four quarters of an instruction cycle are four clocks.
package bab_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned QUARTERS = 4;
    // widths
    localparam int unsigned WORD_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned PC_W = 21;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned FLAG_W = 5;
    // opcode fields
    localparam logic [7:0] OP_ADD_LIT = 8'h0f;
    localparam logic [7:0] OP_AND_LIT = 8'h0b;
    localparam logic [5:0] OP_ADD_FILE_C = 6'h08;
    localparam logic [5:0] OP_ADD_FILE = 6'h09;
    localparam logic [5:0] OP_AND_FILE = 6'h05;
    localparam logic [3:0] OP_BIT_CLEAR = 4'h9;
    localparam logic [7:0] OP_BR_CARRY = 8'he2;
    localparam logic [7:0] OP_BR_NEG = 8'he6;
    // bit positions inside the instruction word
    localparam int unsigned DEST_BIT = 9;
    localparam int unsigned ACC_BIT = 8;
    localparam int unsigned BITSEL_LSB = 9;
    // flag positions in the status vector
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_DC = 1;
    localparam int unsigned FLG_Z = 2;
    localparam int unsigned FLG_OV = 3;
    localparam int unsigned FLG_N = 4;
    // addressing
    localparam logic [7:0] INDEX_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    // reset values and increments
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    typedef enum logic [1:0] {
        BAB_DECODE,
        BAB_READ,
        BAB_PROCESS,
        BAB_WRITE
    } bab_phase_type;
endpackage

// ### test/bab_core_tb.sv
// bab_core_tb: self-checking bench for the byte alu / branch execute unit.
// assumes the core as sole dut; the bench plays fetch and data memory itself.
`timescale 1ns/1ps
module bab_core_tb;
    import bab_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [WORD_W-1:0] instr_word = '0;
    logic instr_valid = 1'b0;
    logic instr_ready;
    logic ext_set_enable = 1'b0;
    logic [BANK_W-1:0] bank_select_reg = 4'h3;
    logic [ADDR_W-1:0] index_base = 12'h100;
    logic [ADDR_W-1:0] mem_addr;
    logic mem_re;
    logic [DATA_W-1:0] mem_rdata = 8'h00;
    logic mem_we;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] acc;
    logic [FLAG_W-1:0] status;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] e_acc = ACC_RESET;
    logic [FLAG_W-1:0] e_st = FLAGS_RESET;
    logic [PC_W-1:0] e_pc = PC_RESET;
    logic wr;
    logic rs;
    logic [DATA_W-1:0] wd;
    int ncyc;
    int n_mismatch = 0;
    int comparisons = 0;

    bab_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .ext_set_enable(ext_set_enable),
        .bank_select_reg(bank_select_reg), .index_base(index_base), .mem_addr(mem_addr),
        .mem_re(mem_re), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .acc(acc), .status(status), .pc(pc));

    always #5 sys_clk = ~sys_clk;

    task automatic print_verdict;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic check_state;
        chk("acc", acc, e_acc);
        chk("status", status, e_st);
        chk("pc", pc, e_pc);
    endtask

    // sum plus flags {n,ov,z,dc,c} ahead of the byte
    function automatic logic [12:0] add_model(input logic [7:0] a, b, input logic ci);
        logic [8:0] s;
        logic [4:0] f;
        s = a + b + ci;
        f = '0;
        f[FLG_C] = s[8];
        f[FLG_DC] = ({1'b0, a[3:0]} + b[3:0] + ci) > 5'h0f;
        f[FLG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
        f[FLG_Z] = s[7:0] == 8'h00;
        f[FLG_N] = s[7];
        return {f, s[7:0]};
    endfunction

    // one instruction; memory answers rd, then shows its inverse so stale data is caught
    task automatic exec(input logic [15:0] w, input logic [7:0] rd);
        int i;
        wr = 1'b0;
        ncyc = 0;
        for (i = 0; i < 20; i++) begin
            if (instr_ready === 1'b1) break;
            @(negedge sys_clk);
        end
        if (i == 20) begin
            n_mismatch++;
            print_verdict;
        end
        instr_word = w;
        instr_valid = 1'b1;
        mem_rdata = rd;
        @(negedge sys_clk);
        // read strobe stands only in the quarter right after the take
        rs = mem_re;
        instr_valid = 1'b0;
        ncyc = 1;
        for (i = 0; i < 20; i++) begin
            @(negedge sys_clk);
            ncyc++;
            if (mem_we === 1'b1) begin
                wr = 1'b1;
                wd = mem_wdata;
            end
            if (instr_ready === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            print_verdict;
        end
        mem_rdata = ~rd;
        e_pc = e_pc + PC_STEP;
    endtask

    task automatic addl(input logic [7:0] k);
        exec({OP_ADD_LIT, k}, 8'h00);
        {e_st, e_acc} = add_model(e_acc, k, 1'b0);
        check_state;
        chk("lit_cycles", ncyc, QUARTERS);
    endtask

    task automatic andl(input logic [7:0] k);
        exec({OP_AND_LIT, k}, 8'h00);
        e_acc = e_acc & k;
        e_st[FLG_Z] = e_acc == 8'h00;
        e_st[FLG_N] = e_acc[7];
        check_state;
        chk("lit_write", wr, 1'b0);
        chk("lit_re", rs, 1'b0);
    endtask

    task automatic t_lit;
        addl(8'h80);
        addl(8'h80);
        addl(8'ha3);
        andl(8'h5f);
    endtask

    // add with carry, add, and; both destinations, banked address
    task automatic t_file;
        logic [5:0] ops [3] = '{OP_ADD_FILE_C, OP_ADD_FILE, OP_AND_FILE};
        logic [7:0] r;
        logic d;
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 2; j++) begin
                d = j[0];
                exec({ops[k], d, 1'b1, 8'h42}, 8'h7f);
                if (k == 2) begin
                    r = e_acc & 8'h7f;
                    e_st[FLG_Z] = r == 8'h00;
                    e_st[FLG_N] = r[7];
                end else begin
                    {e_st, r} = add_model(e_acc, 8'h7f, (k == 0) ? e_st[FLG_C] : 1'b0);
                end
                if (!d) e_acc = r;
                check_state;
                chk("file_we", wr, d);
                if (d) chk("file_wdata", wd, r);
                chk("file_addr", mem_addr, 12'h342);
                chk("file_re", rs, 1'b1);
            end
        end
    endtask

    // access bank split, and indexed offset at 5fh and just past the limit at 60h
    task automatic t_bitclr;
        logic [11:0] ea [4] = '{12'h020, 12'hf70, 12'h15f, 12'hf60};
        logic [7:0] fa [4] = '{8'h20, 8'h70, 8'h5f, 8'h60};
        for (int b = 0; b < 8; b++) begin
            ext_set_enable = b[1];
            exec({OP_BIT_CLEAR, b[2:0], 1'b0, fa[b % 4]}, 8'hff);
            check_state;
            chk("bclr_we", wr, 1'b1);
            chk("bclr_data", wd, 8'hff & ~(8'h01 << b));
            chk("bclr_addr", mem_addr, ea[b % 4]);
            chk("bclr_re", rs, 1'b1);
        end
        ext_set_enable = 1'b0;
    endtask

    task automatic br(input logic [7:0] op, input logic [7:0] n, input int fl);
        logic tk;
        tk = e_st[fl];
        exec({op, n}, 8'h00);
        if (tk) e_pc = e_pc + {{12{n[7]}}, n, 1'b0};
        check_state;
        chk("br_cycles", ncyc, tk ? 2 * QUARTERS : QUARTERS);
    endtask

    task automatic t_branch;
        andl(8'h00);
        addl(8'h80);
        br(OP_BR_NEG, 8'h7f, FLG_N);
        br(OP_BR_CARRY, 8'h80, FLG_C);
        addl(8'h80);
        br(OP_BR_CARRY, 8'h80, FLG_C);
        br(OP_BR_NEG, 8'h7f, FLG_N);
    endtask

    initial begin
        repeat (16) @(negedge sys_clk);
        check_state;
        chk("rst_ready", instr_ready, 1'b0);
        chk("rst_we", {mem_we, mem_re}, 2'b00);
        reset_n = 1'b1;
        t_lit;
        t_file;
        t_bitclr;
        t_branch;
        print_verdict;
    end
endmodule
